// File: rtl/cpu_regs_pkg.sv
// constants and carriers for the banked cpu register file
// assumes one core clock (pclk), async active-low reset, apb software view
//
// Functional notes
// - thirteen architectural registers, banked ones counted once
// - data, address and frame base registers form a bank, two banks exist
// - four 16-bit data registers usable for transfer and arithmetic
// - data registers zero and one split into upper and lower bytes
// - pairs: register two over zero, register three over one, 32 bits
// - two 16-bit address registers for indirect, relative and arithmetic use
// - address register one over zero forms a 32-bit address pair
// - 16-bit frame base supplies frame-relative base
// - 20-bit vector table base holds interrupt table start
// - 20-bit program counter holds next instruction address
// - user and interrupt stack pointers, stack-select flag picks active one
// - 16-bit static base supplies static-base-relative base
// - flag register is 11 bits and reflects processor state
// - carry flag takes carry, borrow or shifted-out bit from alu
// - zero flag set when arithmetic result is zero, else cleared
// - sign flag set when arithmetic result negative, else cleared
// - bank-select flag zero uses bank zero, one uses bank one
// - overflow flag set on overflow, else cleared
package cpu_regs_pkg;

   // register selector codes, also the apb word index
   typedef enum logic [4:0] {
      SEL_DATA0     = 5'h00,
      SEL_DATA1     = 5'h01,
      SEL_DATA2     = 5'h02,
      SEL_DATA3     = 5'h03,
      SEL_ADDR0     = 5'h04,
      SEL_ADDR1     = 5'h05,
      SEL_FRAME     = 5'h06,
      SEL_VECTOR    = 5'h07,
      SEL_PC        = 5'h08,
      SEL_USP       = 5'h09,
      SEL_ISP       = 5'h0A,
      SEL_STATIC    = 5'h0B,
      SEL_FLAGS     = 5'h0C,
      SEL_D0_LOW    = 5'h0D,
      SEL_D0_HIGH   = 5'h0E,
      SEL_D1_LOW    = 5'h0F,
      SEL_D1_HIGH   = 5'h10,
      SEL_PAIR_EVEN = 5'h11,
      SEL_PAIR_ODD  = 5'h12,
      SEL_PAIR_ADDR = 5'h13,
      SEL_SP        = 5'h14
   } reg_sel_e;

   localparam int unsigned REG_COUNT    = 13;
   localparam int unsigned LAST_SEL     = 20;
   localparam logic [11:0] APB_ADDR_MAX = 12'h050;

   // flag layout
   localparam int unsigned FLAG_WIDTH   = 11;
   localparam int unsigned FLAG_CARRY   = 0;
   localparam int unsigned FLAG_DEBUG   = 1;
   localparam int unsigned FLAG_ZERO    = 2;
   localparam int unsigned FLAG_SIGN    = 3;
   localparam int unsigned FLAG_BANK    = 4;
   localparam int unsigned FLAG_OVFL    = 5;
   localparam int unsigned FLAG_STACK   = 7;

   localparam logic [15:0] WORD_RESET   = 16'h0000;
   localparam logic [19:0] ADDR20_RESET = 20'h00000;
   localparam logic [10:0] FLAG_RESET   = 11'h000;

   // alu flag update: which flags to write and their values
   typedef struct packed {
      logic carry_we;
      logic carry;
      logic zs_we;
      logic zero;
      logic sign;
      logic ovfl_we;
      logic ovfl;
   } alu_flags_s;

   typedef struct packed {
      logic        en;
      reg_sel_e    sel;
      logic [31:0] data;
   } reg_write_s;

endpackage

// File: rtl/cpu_register_file_banked.sv
// banked cpu register file with flag register
// assumes the execution unit drives one write port, two read ports and alu flags
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module cpu_register_file_banked (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire cpu_regs_pkg::reg_write_s  core_wr,
   input  wire cpu_regs_pkg::reg_sel_e    rd_sel_a,
   input  wire cpu_regs_pkg::reg_sel_e    rd_sel_b,
   input  wire cpu_regs_pkg::alu_flags_s  alu_flags,
   input  wire logic                      pc_load,
   input  wire logic [19:0]               pc_next,
   output logic      [31:0]               rd_data_a,
   output logic      [31:0]               rd_data_b,
   output logic      [19:0]               pc_out,
   output logic      [15:0]               active_sp,
   output logic      [15:0]               frame_base_out,
   output logic      [15:0]               static_base_out,
   output logic      [19:0]               vector_base_out,
   output logic      [10:0]               flags_out
);

   // bank storage: index 0..3 data, 4..5 address, 6 frame base
   logic [15:0] bank_reg [2][7];
   logic [19:0] vector_table_base_reg;
   logic [19:0] program_counter_reg;
   logic [15:0] user_stack_pointer_reg;
   logic [15:0] interrupt_stack_pointer_reg;
   logic [15:0] static_base_reg;
   logic [10:0] cpu_flags_reg;
   logic [31:0] rd_a_reg;
   logic [31:0] rd_b_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic [15:0] active_sp_reg;
   logic [15:0] frame_base_reg;

   logic             bank;
   logic             apb_acc;
   logic             apb_done;
   logic             apb_bad;
   cpu_regs_pkg::reg_write_s wr;

   assign bank = cpu_flags_reg[cpu_regs_pkg::FLAG_BANK];

   // true for an aligned, mapped apb byte address
   function automatic logic addr_valid(input logic [11:0] a);
      return (a[1:0] == 2'h0) && (a <= cpu_regs_pkg::APB_ADDR_MAX);
   endfunction

   // read a register view through the current bank and stack selection
   function automatic logic [31:0] view(input cpu_regs_pkg::reg_sel_e s);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (s)
         cpu_regs_pkg::SEL_DATA0:     v = {16'h0000, bank_reg[bank][0]};
         cpu_regs_pkg::SEL_DATA1:     v = {16'h0000, bank_reg[bank][1]};
         cpu_regs_pkg::SEL_DATA2:     v = {16'h0000, bank_reg[bank][2]};
         cpu_regs_pkg::SEL_DATA3:     v = {16'h0000, bank_reg[bank][3]};
         cpu_regs_pkg::SEL_ADDR0:     v = {16'h0000, bank_reg[bank][4]};
         cpu_regs_pkg::SEL_ADDR1:     v = {16'h0000, bank_reg[bank][5]};
         cpu_regs_pkg::SEL_FRAME:     v = {16'h0000, bank_reg[bank][6]};
         cpu_regs_pkg::SEL_VECTOR:    v = {12'h000, vector_table_base_reg};
         cpu_regs_pkg::SEL_PC:        v = {12'h000, program_counter_reg};
         cpu_regs_pkg::SEL_USP:       v = {16'h0000, user_stack_pointer_reg};
         cpu_regs_pkg::SEL_ISP:       v = {16'h0000, interrupt_stack_pointer_reg};
         cpu_regs_pkg::SEL_STATIC:    v = {16'h0000, static_base_reg};
         cpu_regs_pkg::SEL_FLAGS:     v = {21'h000000, cpu_flags_reg};
         cpu_regs_pkg::SEL_D0_LOW:    v = {24'h000000, bank_reg[bank][0][7:0]};
         cpu_regs_pkg::SEL_D0_HIGH:   v = {24'h000000, bank_reg[bank][0][15:8]};
         cpu_regs_pkg::SEL_D1_LOW:    v = {24'h000000, bank_reg[bank][1][7:0]};
         cpu_regs_pkg::SEL_D1_HIGH:   v = {24'h000000, bank_reg[bank][1][15:8]};
         cpu_regs_pkg::SEL_PAIR_EVEN: v = {bank_reg[bank][2], bank_reg[bank][0]};
         cpu_regs_pkg::SEL_PAIR_ODD:  v = {bank_reg[bank][3], bank_reg[bank][1]};
         cpu_regs_pkg::SEL_PAIR_ADDR: v = {bank_reg[bank][5], bank_reg[bank][4]};
         cpu_regs_pkg::SEL_SP:        v = cpu_flags_reg[cpu_regs_pkg::FLAG_STACK] ?
                                          {16'h0000, interrupt_stack_pointer_reg} :
                                          {16'h0000, user_stack_pointer_reg};
         default:                     v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // one wait state; a write lands at the edge that completes the transfer and beats the core port
   assign apb_acc  = psel && penable && !pready_reg;
   assign apb_done = psel && penable && pready_reg;
   assign apb_bad  = !addr_valid(paddr);

   always_comb begin
      wr = core_wr;
      if (apb_done && pwrite && !apb_bad) begin
         wr.en   = 1'b1;
         wr.sel  = cpu_regs_pkg::reg_sel_e'(paddr[6:2]);
         wr.data = pwdata;
      end
   end

   // banked registers with byte and pair write views
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 7; i++) begin
               bank_reg[b][i] <= cpu_regs_pkg::WORD_RESET;
            end
         end
      end else if (wr.en) begin
         unique case (wr.sel)
            cpu_regs_pkg::SEL_DATA0:     bank_reg[bank][0] <= wr.data[15:0];
            cpu_regs_pkg::SEL_DATA1:     bank_reg[bank][1] <= wr.data[15:0];
            cpu_regs_pkg::SEL_DATA2:     bank_reg[bank][2] <= wr.data[15:0];
            cpu_regs_pkg::SEL_DATA3:     bank_reg[bank][3] <= wr.data[15:0];
            cpu_regs_pkg::SEL_ADDR0:     bank_reg[bank][4] <= wr.data[15:0];
            cpu_regs_pkg::SEL_ADDR1:     bank_reg[bank][5] <= wr.data[15:0];
            cpu_regs_pkg::SEL_FRAME:     bank_reg[bank][6] <= wr.data[15:0];
            cpu_regs_pkg::SEL_D0_LOW:    bank_reg[bank][0][7:0] <= wr.data[7:0];
            cpu_regs_pkg::SEL_D0_HIGH:   bank_reg[bank][0][15:8] <= wr.data[7:0];
            cpu_regs_pkg::SEL_D1_LOW:    bank_reg[bank][1][7:0] <= wr.data[7:0];
            cpu_regs_pkg::SEL_D1_HIGH:   bank_reg[bank][1][15:8] <= wr.data[7:0];
            cpu_regs_pkg::SEL_PAIR_EVEN: begin
               bank_reg[bank][0] <= wr.data[15:0];
               bank_reg[bank][2] <= wr.data[31:16];
            end
            cpu_regs_pkg::SEL_PAIR_ODD: begin
               bank_reg[bank][1] <= wr.data[15:0];
               bank_reg[bank][3] <= wr.data[31:16];
            end
            cpu_regs_pkg::SEL_PAIR_ADDR: begin
               bank_reg[bank][4] <= wr.data[15:0];
               bank_reg[bank][5] <= wr.data[31:16];
            end
            default: ;
         endcase
      end
   end

   // unbanked base registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_table_base_reg <= cpu_regs_pkg::ADDR20_RESET;
         static_base_reg       <= cpu_regs_pkg::WORD_RESET;
      end else if (wr.en) begin
         if (wr.sel == cpu_regs_pkg::SEL_VECTOR) begin
            vector_table_base_reg <= wr.data[19:0];
         end
         if (wr.sel == cpu_regs_pkg::SEL_STATIC) begin
            static_base_reg <= wr.data[15:0];
         end
      end
   end

   // stack pointers; the sp view writes the one chosen by the stack flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         user_stack_pointer_reg      <= cpu_regs_pkg::WORD_RESET;
         interrupt_stack_pointer_reg <= cpu_regs_pkg::WORD_RESET;
      end else if (wr.en) begin
         if (wr.sel == cpu_regs_pkg::SEL_USP ||
             (wr.sel == cpu_regs_pkg::SEL_SP && !cpu_flags_reg[cpu_regs_pkg::FLAG_STACK])) begin
            user_stack_pointer_reg <= wr.data[15:0];
         end
         if (wr.sel == cpu_regs_pkg::SEL_ISP ||
             (wr.sel == cpu_regs_pkg::SEL_SP && cpu_flags_reg[cpu_regs_pkg::FLAG_STACK])) begin
            interrupt_stack_pointer_reg <= wr.data[15:0];
         end
      end
   end

   // program counter: explicit register write beats sequencing load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter_reg <= cpu_regs_pkg::ADDR20_RESET;
      end else if (wr.en && wr.sel == cpu_regs_pkg::SEL_PC) begin
         program_counter_reg <= wr.data[19:0];
      end else if (pc_load) begin
         program_counter_reg <= pc_next;
      end
   end

   // flag register; alu updates win over a whole-register write on their bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_flags_reg <= cpu_regs_pkg::FLAG_RESET;
      end else begin
         if (wr.en && wr.sel == cpu_regs_pkg::SEL_FLAGS) begin
            cpu_flags_reg <= wr.data[10:0];
         end
         if (alu_flags.carry_we) begin
            cpu_flags_reg[cpu_regs_pkg::FLAG_CARRY] <= alu_flags.carry;
         end
         if (alu_flags.zs_we) begin
            cpu_flags_reg[cpu_regs_pkg::FLAG_ZERO] <= alu_flags.zero;
            cpu_flags_reg[cpu_regs_pkg::FLAG_SIGN] <= alu_flags.sign;
         end
         if (alu_flags.ovfl_we) begin
            cpu_flags_reg[cpu_regs_pkg::FLAG_OVFL] <= alu_flags.ovfl;
         end
      end
   end

   // registered core read ports a and b
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_a_reg <= 32'h0000_0000;
         rd_b_reg <= 32'h0000_0000;
      end else begin
         rd_a_reg <= view(rd_sel_a);
         rd_b_reg <= view(rd_sel_b);
      end
   end

   // apb slave: one wait state, error on misaligned or unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= apb_acc;
         pslverr_reg <= apb_acc && apb_bad;
         if (apb_acc && !pwrite) begin
            prdata_reg <= apb_bad ? 32'h0000_0000 : view(cpu_regs_pkg::reg_sel_e'(paddr[6:2]));
         end
      end
   end

   // registered copies of the muxed base outputs; they trail a flag or register change by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_sp_reg  <= cpu_regs_pkg::WORD_RESET;
         frame_base_reg <= cpu_regs_pkg::WORD_RESET;
      end else begin
         active_sp_reg  <= cpu_flags_reg[cpu_regs_pkg::FLAG_STACK] ?
                           interrupt_stack_pointer_reg : user_stack_pointer_reg;
         frame_base_reg <= bank_reg[bank][6];
      end
   end

   assign prdata          = prdata_reg;
   assign pready          = pready_reg;
   assign pslverr         = pslverr_reg;
   assign rd_data_a       = rd_a_reg;
   assign rd_data_b       = rd_b_reg;
   assign pc_out          = program_counter_reg;
   assign active_sp       = active_sp_reg;
   assign frame_base_out  = frame_base_reg;
   assign static_base_out = static_base_reg;
   assign vector_base_out = vector_table_base_reg;
   assign flags_out       = cpu_flags_reg;

endmodule

// File: verif/cpu_regs_monitor.sv
// assertion checker for the banked cpu register file
// assumes it is bound to cpu_register_file_banked and sees only its ports
`timescale 1ns/1ps
module cpu_regs_monitor (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [11:0]              paddr,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire cpu_regs_pkg::reg_write_s core_wr,
   input wire cpu_regs_pkg::reg_sel_e   rd_sel_a,
   input wire cpu_regs_pkg::reg_sel_e   rd_sel_b,
   input wire cpu_regs_pkg::alu_flags_s alu_flags,
   input wire logic                     pc_load,
   input wire logic [19:0]              pc_next,
   input wire logic [31:0]              rd_data_a,
   input wire logic [31:0]              rd_data_b,
   input wire logic [19:0]              pc_out,
   input wire logic [10:0]              flags_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic pc_apb;
   logic pc_core;
   assign pc_apb = psel && penable && pready && pwrite && paddr == 12'h020;
   assign pc_core = core_wr.en && core_wr.sel == cpu_regs_pkg::SEL_PC;

   carry_flag_a: assert property (
      alu_flags.carry_we |=> flags_out[cpu_regs_pkg::FLAG_CARRY] == $past(alu_flags.carry))
      else $error("carry flag not updated");
   zero_flag_a: assert property (
      alu_flags.zs_we |=> flags_out[cpu_regs_pkg::FLAG_ZERO] == $past(alu_flags.zero))
      else $error("zero flag not updated");
   sign_flag_a: assert property (
      alu_flags.zs_we |=> flags_out[cpu_regs_pkg::FLAG_SIGN] == $past(alu_flags.sign))
      else $error("sign flag not updated");
   ovfl_flag_a: assert property (
      alu_flags.ovfl_we |=> flags_out[cpu_regs_pkg::FLAG_OVFL] == $past(alu_flags.ovfl))
      else $error("overflow flag not updated");
   pc_load_a: assert property (
      pc_load && !pc_apb && !pc_core |=> pc_out == $past(pc_next))
      else $error("program counter not loaded");
   flags_read_a: assert property (
      rd_sel_a == cpu_regs_pkg::SEL_FLAGS |=> rd_data_a == {21'h0, $past(flags_out)})
      else $error("flag read port wrong");
   pc_read_a: assert property (
      rd_sel_b == cpu_regs_pkg::SEL_PC |=> rd_data_b == {12'h0, $past(pc_out)})
      else $error("pc read port wrong");
   apb_answer_a: assert property (
      psel && penable && !pready |=> pready && pslverr == (paddr > 12'h050 || paddr[1:0] != 2'h0))
      else $error("apb answer wrong");
endmodule

bind cpu_register_file_banked cpu_regs_monitor i_mon (.*);

// File: verif/exec_unit_model.sv
// model of the execution unit on the core side of the register file
// assumes its tasks are called from the bench just after a rising edge
`timescale 1ns/1ps
module exec_unit_model (
   input  wire logic               pclk,
   output cpu_regs_pkg::reg_write_s core_wr,
   output cpu_regs_pkg::reg_sel_e   rd_sel_a,
   output cpu_regs_pkg::reg_sel_e   rd_sel_b,
   output cpu_regs_pkg::alu_flags_s alu_flags,
   output logic                     pc_load,
   output logic [19:0]              pc_next
);
   initial begin
      core_wr = '0;
      rd_sel_a = cpu_regs_pkg::SEL_DATA0;
      rd_sel_b = cpu_regs_pkg::SEL_DATA0;
      alu_flags = '0;
      pc_load = 1'h0;
      pc_next = 20'h00000;
   end
   task automatic core_put(input cpu_regs_pkg::reg_sel_e s, input logic [31:0] d);
      logic [31:0] v;
      v = d;
      if (s == cpu_regs_pkg::SEL_FLAGS) v[cpu_regs_pkg::FLAG_DEBUG] = 1'h0;
      @(posedge pclk);
      core_wr <= '{en: 1'h1, sel: s, data: v};
      @(posedge pclk);
      core_wr.en <= 1'h0;
   endtask
   task automatic alu(input cpu_regs_pkg::alu_flags_s f);
      @(posedge pclk);
      alu_flags <= f;
      @(posedge pclk);
      alu_flags <= '0;
   endtask
   task automatic load_pc(input logic [19:0] v);
      @(posedge pclk);
      pc_load <= 1'h1;
      pc_next <= v;
      @(posedge pclk);
      pc_load <= 1'h0;
   endtask
   task automatic select(input cpu_regs_pkg::reg_sel_e a, input cpu_regs_pkg::reg_sel_e b);
      @(posedge pclk);
      rd_sel_a <= a;
      rd_sel_b <= b;
      repeat (3) @(posedge pclk);
   endtask
endmodule

// File: verif/tb.sv
// self-checking bench for the banked cpu register file
// assumes the execution unit model drives the core side
`timescale 1ns/1ps
module tb;
   logic                     pclk;
   logic                     presetn;
   logic                     psel;
   logic                     penable;
   logic                     pwrite;
   logic                     pready;
   logic                     pslverr;
   logic                     pc_load;
   logic                     e;
   logic [11:0]              paddr;
   logic [31:0]              pwdata;
   logic [31:0]              prdata;
   logic [31:0]              rd_data_a;
   logic [31:0]              rd_data_b;
   logic [31:0]              r;
   logic [19:0]              pc_out;
   logic [19:0]              vector_base_out;
   logic [19:0]              pc_next;
   logic [15:0]              active_sp;
   logic [15:0]              frame_base_out;
   logic [15:0]              static_base_out;
   logic [10:0]              flags_out;
   cpu_regs_pkg::reg_write_s core_wr;
   cpu_regs_pkg::reg_sel_e   rd_sel_a;
   cpu_regs_pkg::reg_sel_e   rd_sel_b;
   cpu_regs_pkg::alu_flags_s alu_flags;
   int                       bad_count = 0;
   int                       n_tests = 0;
   int                       cycles = 0;

   cpu_register_file_banked i_dut (.*);
   exec_unit_model i_core (.*);

   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic stop_test();
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(r, x);
   endtask
   task automatic reg_walk();
      logic [31:0] m;
      for (int i = 0; i < 12; i++) begin
         m = (i == 7 || i == 8) ? 32'h000F_FFFF : 32'h0000_FFFF;
         rd(12'(i * 4), 32'h0);
         wr(12'(i * 4), 32'h5A5A_5A5A ^ i);
         rd(12'(i * 4), (32'h5A5A_5A5A ^ i) & m);
      end
      rd(12'h030, 32'h0);
      chk({12'h0, vector_base_out}, 32'h000A_5A5D);
      chk({12'h0, pc_out}, 32'h000A_5A52);
      chk({16'h0, static_base_out}, 32'h0000_5A51);
   endtask
   task automatic views();
      wr(12'h034, 32'hC3);
      wr(12'h038, 32'h7E);
      rd(12'h000, 32'h7EC3);
      rd(12'h038, 32'h7E);
      wr(12'h044, 32'h89AB_CDEF);
      rd(12'h000, 32'hCDEF);
      rd(12'h008, 32'h89AB);
      wr(12'h048, 32'h1357_2468);
      wr(12'h03C, 32'h11);
      wr(12'h040, 32'h66);
      rd(12'h048, 32'h1357_6611);
      rd(12'h034, 32'hEF);
      wr(12'h04C, 32'hFEDC_BA98);
      rd(12'h014, 32'hFEDC);
      rd(12'h010, 32'hBA98);
   endtask
   task automatic bank();
      wr(12'h018, 32'h1111);
      wr(12'h000, 32'hAAAA);
      wr(12'h030, 32'h10);
      wr(12'h000, 32'h5555);
      wr(12'h018, 32'h2222);
      repeat (2) @(posedge pclk);
      chk({16'h0, frame_base_out}, 32'h2222);
      wr(12'h030, 32'h0);
      rd(12'h000, 32'hAAAA);
      chk({16'h0, frame_base_out}, 32'h1111);
   endtask
   task automatic stack();
      logic [15:0] a0;
      wr(12'h024, 32'h0AAA);
      wr(12'h028, 32'h0BBB);
      a0 = active_sp;
      wr(12'h030, 32'h80);
      repeat (2) @(posedge pclk);
      chk({a0, active_sp}, 32'h0AAA_0BBB);
      rd(12'h050, 32'h0BBB);
      wr(12'h050, 32'h0CCC);
      rd(12'h028, 32'h0CCC);
      wr(12'h030, 32'h0);
   endtask
   task automatic flags();
      i_core.alu(7'h7B);
      @(posedge pclk);
      chk({21'h0, flags_out}, 32'h025);
      i_core.alu(7'h56);
      @(posedge pclk);
      chk({21'h0, flags_out}, 32'h008);
      i_core.alu(7'h20);
      rd(12'h030, 32'h008);
   endtask
   task automatic core();
      i_core.core_put(cpu_regs_pkg::SEL_DATA3, 32'hBEEF);
      i_core.load_pc(20'hABCDE);
      i_core.select(cpu_regs_pkg::SEL_DATA3, cpu_regs_pkg::SEL_PC);
      chk(rd_data_a, 32'hBEEF);
      chk(rd_data_b, 32'h000A_BCDE);
      apb(1'h0, 12'h054, 32'h0);
      chk({r[31:1], e}, 32'h1);
      apb(1'h1, 12'h002, 32'hFFFF);
      chk({31'h0, e}, 32'h1);
      rd(12'h000, 32'hAAAA);
      i_core.core_put(cpu_regs_pkg::SEL_FLAGS, 32'h7FF);
      i_core.select(cpu_regs_pkg::SEL_FLAGS, cpu_regs_pkg::SEL_PC);
      chk(rd_data_a, 32'h7FD);
   endtask
   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      reg_walk();
      views();
      bank();
      stack();
      flags();
      core();
      stop_test();
   end
endmodule
